/* verilog/fdc_unit.sv */
// Floating-point divide, convert and load datapath with Wishbone registers.
`timescale 1ns/1ps

module fdc_unit
  import fdc_pkg::*;
#(
  // Unit identification code; the value is arbitrary.
  parameter logic [3:0] ID_CODE = 4'h5
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic RST_N,
  // Wishbone slave request.
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  // Wishbone slave answer.
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O
);

  // Merges write data into an old word under the byte enables.
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // Normalizes a mantissa by whole hex digits; an empty one is true zero.
  function automatic logic [63:0] norm_float(input logic s,
      input logic [6:0] e, input logic [55:0] m);
    logic [55:0] mm;
    logic [6:0] ee;
    mm = m;
    ee = e;
    for (int i = 0; i < 13; i++) begin
      if (mm[55:52] == 4'h0) begin
        mm = mm << 4;
        ee = ee - 7'h01;
      end
    end
    return (mm == '0) ? 64'h0 : {s, ee, mm};
  endfunction

  // Sets Z and N from a float result.
  function automatic logic [31:0] set_zn(input logic [31:0] st,
      input logic [63:0] f);
    logic [31:0] r;
    r = st;
    r[ST_Z] = (f[MANT_W-1:0] == '0);
    r[ST_N] = f[F_SIGN];
    return r;
  endfunction

  // Fixes a float: overflow flag beyond a 16-bit (accumulator) or 32-bit (memory) two's complement word.
  function automatic logic [32:0] fix_word(input logic [63:0] f,
      input logic wide);
    logic [119:0] sh;
    logic [63:0] mag;
    logic [63:0] lim;
    logic [31:0] low;
    logic [7:0] ex;
    logic big;
    ex = {1'b0, f[62:F_EXP_LSB]};
    sh = {64'h0, f[MANT_W-1:0]} << (4 * (ex - EXP_BIAS));
    big = (ex > EXP_BIAS + INT_DIGITS);
    mag = (ex <= EXP_BIAS) ? 64'h0 : sh[119:56];
    lim = wide ? FIX_MEM_LIMIT : FIX_ACC_LIMIT;
    low = wide ? {1'b0, mag[30:0]} : {17'h0, mag[14:0]};
    fix_word[32] = big | (f[F_SIGN] ? (mag > lim) : (mag >= lim));
    // The most negative integer keeps its sign; other zero parts do not.
    fix_word[31:0] = (f[F_SIGN] && mag == lim && !big) ? lim[31:0] :
                     (f[F_SIGN] ? -low : low);
  endfunction

  // True when float a is algebraically greater than float b.
  function automatic logic flt_gt(input logic [63:0] a, input logic [63:0] b);
    if (a[F_SIGN] != b[F_SIGN]) return b[F_SIGN];
    else if (!a[F_SIGN]) return a[62:0] > b[62:0];
    else return a[62:0] < b[62:0];
  endfunction

  // Architectural state.
  logic [63:0] fpac [4]; // Four float accumulators.
  logic [15:0] fixed_acc; // Fixed accumulator zero.
  logic [31:0] float_status_reg; // Flags, error bits and ID code.
  logic [31:0] opnd_hi; // Words 0 and 1 of the memory operand.
  logic [31:0] opnd_lo; // Words 2 and 3 of the memory operand.
  logic [31:0] fix_result; // Fix-to-memory result for the core.
  logic [CMD_W-1:0] cmd; // Last accepted command.
  fdc_state_t state; // Sequencer state.

  // Divider state.
  logic [59:0] rem; // Partial remainder.
  logic [58:0] dsr; // Divisor mantissa scaled by eight.
  logic [63:0] quo; // Quotient bits, four integer bits first.
  logic [6:0] step; // Quotient bit counter.
  logic q_sign; // Quotient sign.
  logic [9:0] q_exp; // Unwrapped quotient exponent.

  // Command fields and operand selection.
  wire [4:0] op = cmd[CMD_OP_LSB +: 5];
  wire [1:0] dst = cmd[CMD_DST_LSB +: 2];
  wire [1:0] src = cmd[CMD_SRC_LSB +: 2];
  wire [63:0] fd = fpac[dst];
  wire [63:0] fs = fpac[src];
  wire busy = (state != S_IDLE);
  wire is_single = (op == OP_DIV_SINGLE_MEM) || (op == OP_DIV_SINGLE_REG);
  wire is_div = is_single || (op == OP_DIV_DOUBLE_REG) ||
                (op == OP_DIV_DOUBLE_MEM);
  // Memory operands: most significant word sits at the effective address.
  wire [63:0] mem_double = {opnd_hi, opnd_lo};
  wire [63:0] mem_single = {opnd_hi, 32'h0};
  wire [63:0] dividend = is_single ? {fd[63:32], 32'h0} : fd;
  wire [63:0] divisor = (op == OP_DIV_DOUBLE_REG) ? fs :
                        (op == OP_DIV_DOUBLE_MEM) ? mem_double :
                        (op == OP_DIV_SINGLE_MEM) ? mem_single :
                        {fs[63:32], 32'h0};
  wire dvd_zero = (dividend[MANT_W-1:0] == '0);
  wire dvs_zero = (divisor[MANT_W-1:0] == '0);
  wire div_go = (state == S_EXEC) && is_div && !dvd_zero && !dvs_zero;

  // Bus decode; writes land on the edge where ack is seen high.
  wire bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire bus_wr = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O & ~busy;
  wire hit_fpac = (WB_ADR_I[7:5] == ADDR_FPAC_BASE[7:5]);
  wire [1:0] fp_idx = WB_ADR_I[4:3];
  wire fp_low = WB_ADR_I[2];
  wire [63:0] fp_rd = fpac[fp_idx];
  wire [31:0] fp_word = fp_low ? fp_rd[31:0] : fp_rd[63:32];
  wire [31:0] cmd_rd = {busy, {(31-CMD_W){1'b0}}, cmd};
  wire [31:0] rd_data =
    (WB_ADR_I == ADDR_CMD) ? cmd_rd :
    (WB_ADR_I == ADDR_FIXED) ? {16'h0, fixed_acc} :
    (WB_ADR_I == ADDR_STATUS) ? float_status_reg :
    (WB_ADR_I == ADDR_OPND_HI) ? opnd_hi :
    (WB_ADR_I == ADDR_OPND_LO) ? opnd_lo :
    (WB_ADR_I == ADDR_FIX_RES) ? fix_result :
    hit_fpac ? fp_word : 32'h0;
  wire [31:0] wr_word = merge(rd_data, WB_DAT_I, WB_SEL_I);

  // Divider finish: fold the integer digit and wrap the exponent.
  wire q_big = (quo[63:60] != 4'h0);
  wire [55:0] q_mant = q_big ? quo[63:8] : quo[59:4];
  wire [9:0] q_exp_f = q_exp + {9'h0, q_big};
  wire q_ovf = $signed(q_exp_f) > $signed(EXP_MAX);
  wire q_under = $signed(q_exp_f) < 0;
  wire [63:0] q_full = {q_sign, q_exp_f[6:0], q_mant};
  wire [63:0] q_res = is_single ? {q_full[63:32], 32'h0} : q_full;

  // Halve: right shift into the guard digit, then renormalize.
  wire [59:0] hv_t = {fd[MANT_W-1:0], 4'h0} >> 1;
  wire hv_top = (hv_t[59:56] != 4'h0);
  wire [55:0] hv_m = hv_top ? hv_t[59:4] : hv_t[55:0];
  wire hv_under = !hv_top && (fd[62:F_EXP_LSB] == 7'h00);
  wire [6:0] hv_e = hv_top ? fd[62:F_EXP_LSB] : fd[62:F_EXP_LSB] - 7'h01;
  wire [63:0] hv_res = (hv_m == '0) ? 64'h0 : {fd[F_SIGN], hv_e, hv_m};

  // Integerize: clear mantissa bits below the binary point.
  wire [7:0] in_ex = {1'b0, fd[62:F_EXP_LSB]};
  wire [55:0] in_mask = ~((56'h1 << (MANT_W - 4 * (in_ex - EXP_BIAS)))
                          - 56'h1);
  wire [63:0] in_res = (in_ex <= EXP_BIAS) ? 64'h0 :
                       (in_ex >= EXP_BIAS + KEEP_DIGITS) ? fd :
                       {fd[63:56], fd[MANT_W-1:0] & in_mask};

  // Integer conversions into floats and fixes of floats into integers.
  wire [15:0] fa_mag = fixed_acc[15] ? -fixed_acc : fixed_acc;
  wire [63:0] fa_full = norm_float(fixed_acc[15], EXP_FROM_ACC,
                                   {fa_mag, 40'h0});
  wire [31:0] fm_mag = opnd_hi[31] ? -opnd_hi : opnd_hi;
  wire [63:0] fm_res = norm_float(opnd_hi[31], EXP_FROM_MEM,
                                  {fm_mag, 24'h0});
  wire [32:0] fix_acc = fix_word(fd, 1'b0);
  wire [32:0] fix_mem = fix_word(fd, 1'b1);

  // Execution results, valid while the matching state is held.
  logic ex_wr_fpac;
  logic [63:0] ex_fpac;
  logic [31:0] ex_status;
  logic ex_wr_fixed;
  logic ex_wr_fixres;

  // Computes the one-cycle operations and the divider write-back.
  always_comb begin
    ex_wr_fpac = 1'b0;
    ex_fpac = 64'h0;
    ex_status = float_status_reg;
    ex_wr_fixed = 1'b0;
    ex_wr_fixres = 1'b0;
    if (state == S_DIVEND) begin
      // Quotient write-back with exponent range errors.
      ex_wr_fpac = 1'b1;
      ex_fpac = q_res;
      ex_status = set_zn(float_status_reg, q_res);
      if (q_ovf | q_under) begin
        ex_status[ST_OVF] = float_status_reg[ST_OVF] | q_ovf;
        ex_status[ST_UNDER] = float_status_reg[ST_UNDER] | q_under;
        ex_status[ST_ANY] = 1'b1;
      end
    end else if (state == S_EXEC) begin
      case (op)
        OP_COMPARE: begin
          // Source greater gives N; equality gives Z.
          ex_status[ST_Z] = (fs == fd);
          ex_status[ST_N] = flt_gt(fs, fd);
        end
        OP_DIV_DOUBLE_REG, OP_DIV_DOUBLE_MEM, OP_DIV_SINGLE_MEM,
        OP_DIV_SINGLE_REG: begin
          // Divide by zero leaves the destination alone.
          if (dvs_zero) begin
            ex_status[ST_DVZ] = 1'b1;
            ex_status[ST_ANY] = 1'b1;
          end else if (dvd_zero) begin
            ex_wr_fpac = 1'b1;
            ex_status = set_zn(float_status_reg, 64'h0);
          end
        end
        OP_LOAD_EXPONENT: begin
          // True zero stays; empty mantissa clears sign and exponent.
          ex_wr_fpac = (fd != 64'h0);
          if (fd[MANT_W-1:0] == '0) ex_fpac = 64'h0;
          else ex_fpac = {fd[F_SIGN], fixed_acc[FX_EXP_MSB:FX_EXP_LSB],
                          fd[MANT_W-1:0]};
        end
        OP_FIX_TO_ACC, OP_FIX_TO_MEM: begin
          // Both fixes clear Z and N and raise the mantissa overflow flag when the result does not fit.
          ex_wr_fixed = (op == OP_FIX_TO_ACC);
          ex_wr_fixres = (op == OP_FIX_TO_MEM);
          ex_status[ST_Z] = 1'b0;
          ex_status[ST_N] = 1'b0;
          if ((op == OP_FIX_TO_ACC) ? fix_acc[32] : fix_mem[32]) begin
            ex_status[ST_MANT_OVF] = 1'b1;
            ex_status[ST_ANY] = 1'b1;
          end
        end
        OP_HALVE: begin
          ex_wr_fpac = 1'b1;
          ex_fpac = hv_res;
          ex_status = set_zn(float_status_reg, hv_res);
          if (hv_under && hv_m != '0) begin
            ex_status[ST_UNDER] = 1'b1;
            ex_status[ST_ANY] = 1'b1;
          end
        end
        OP_INTEGERIZE: begin
          ex_wr_fpac = 1'b1;
          ex_fpac = in_res;
          ex_status = set_zn(float_status_reg, in_res);
        end
        OP_FLOAT_FROM_ACC: begin
          ex_wr_fpac = 1'b1;
          ex_fpac = {fa_full[63:32], 32'h0};
          ex_status = set_zn(float_status_reg, fa_full);
        end
        OP_FLOAT_FROM_MEM: begin
          ex_wr_fpac = 1'b1;
          ex_fpac = fm_res;
          ex_status = set_zn(float_status_reg, fm_res);
        end
        OP_LOAD_DOUBLE, OP_LOAD_SINGLE: begin
          // Loaded zero mantissa forces sign and exponent to zero.
          ex_wr_fpac = 1'b1;
          ex_fpac = (op == OP_LOAD_DOUBLE) ? mem_double :
                    mem_single;
          if (ex_fpac[MANT_W-1:0] == '0) ex_fpac = 64'h0;
          ex_status = set_zn(float_status_reg, ex_fpac);
        end
        OP_LOAD_STATUS: begin
          // Loaded bits become the flags; the ID field is kept.
          ex_status = opnd_hi;
          ex_status[ST_ID_MSB:ST_ID_LSB] = ID_CODE;
        end
        default: begin
          ex_status = float_status_reg;
        end
      endcase
    end
  end

  // Wishbone answer: one wait state, ack held for a single cycle.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
    end else begin
      WB_ACK_O <= bus_req;
      if (bus_req) WB_DAT_O <= rd_data;
    end
  end

  // Sequencer: command accepted only while idle.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= S_IDLE;
      cmd <= '0;
    end else begin
      case (state)
        S_IDLE: begin
          if (bus_wr && WB_ADR_I == ADDR_CMD) begin
            cmd <= wr_word[CMD_W-1:0];
            state <= S_EXEC;
          end
        end
        S_EXEC: state <= div_go ? S_DIV : S_IDLE;
        S_DIV: state <= (step == DIV_LAST) ? S_DIVEND : S_DIV;
        S_DIVEND: state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  // Restoring divider, one quotient bit per clock.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rem <= '0;
      dsr <= '0;
      quo <= '0;
      step <= '0;
      q_sign <= 1'b0;
      q_exp <= '0;
    end else if (div_go) begin
      rem <= {4'h0, dividend[MANT_W-1:0]};
      dsr <= {divisor[MANT_W-1:0], 3'h0};
      quo <= '0;
      step <= '0;
      q_sign <= dividend[F_SIGN] ^ divisor[F_SIGN];
      q_exp <= {3'h0, dividend[62:F_EXP_LSB]} -
               {3'h0, divisor[62:F_EXP_LSB]} + {2'h0, EXP_BIAS};
    end else if (state == S_DIV) begin
      rem <= (rem >= {1'b0, dsr}) ? (rem - {1'b0, dsr}) << 1 : rem << 1;
      quo <= {quo[62:0], (rem >= {1'b0, dsr})};
      step <= step + 7'h01;
    end
  end

  // Float accumulators: execution writes, else software writes.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 4; i++) fpac[i] <= 64'h0;
    end else if (ex_wr_fpac) begin
      fpac[dst] <= ex_fpac;
    end else if (bus_wr && hit_fpac) begin
      if (fp_low) fpac[fp_idx][31:0] <= wr_word;
      else fpac[fp_idx][63:32] <= wr_word;
    end
  end

  // Fixed accumulator, memory operand and fix result.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      fixed_acc <= 16'h0;
      opnd_hi <= 32'h0;
      opnd_lo <= 32'h0;
      fix_result <= 32'h0;
    end else begin
      if (ex_wr_fixed) fixed_acc <= fix_acc[15:0];
      else if (bus_wr && WB_ADR_I == ADDR_FIXED) fixed_acc <= wr_word[15:0];
      if (ex_wr_fixres) fix_result <= fix_mem[31:0];
      if (bus_wr && WB_ADR_I == ADDR_OPND_HI) opnd_hi <= wr_word;
      if (bus_wr && WB_ADR_I == ADDR_OPND_LO) opnd_lo <= wr_word;
    end
  end

  // Status register; the ID field is rebuilt from the parameter.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      // The ID field holds its code through reset as well.
      float_status_reg <= STATUS_RESET;
      float_status_reg[ST_ID_MSB:ST_ID_LSB] <= ID_CODE;
    end else begin
      float_status_reg <= ex_status;
      float_status_reg[ST_ID_MSB:ST_ID_LSB] <= ID_CODE;
    end
  end

  // Checks beside the logic.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_ack_single_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  a_ack_after_req: assert property (bus_req |=> WB_ACK_O)
    else $error("request not answered in one cycle");
  a_id_code_fixed: assert property (
    ##1 float_status_reg[ST_ID_MSB:ST_ID_LSB] == ID_CODE)
    else $error("status identification field changed");
  a_div_length_64: assert property (
    $rose(state == S_DIV) |-> ##64 (state == S_DIVEND))
    else $error("divide did not take 64 steps");
  a_single_low_zero: assert property (
    (state == S_DIVEND) && is_single |=> fpac[dst][31:0] == 32'h0)
    else $error("single divide left low bits set");
  a_fix_clears_zn: assert property (
    (state == S_EXEC) && (op == OP_FIX_TO_ACC)
    |=> !float_status_reg[ST_Z] && !float_status_reg[ST_N])
    else $error("fix did not clear Z and N");
  a_cmp_equal_flags: assert property (
    (state == S_EXEC) && (op == OP_COMPARE) && (fs == fd)
    |=> float_status_reg[ST_Z] && !float_status_reg[ST_N])
    else $error("equal compare gave wrong flags");
  a_flt_acc_keep: assert property (
    (state == S_EXEC) && (op == OP_FLOAT_FROM_ACC)
    |=> fpac[dst][31:0] == 32'h0 && fixed_acc == $past(fixed_acc))
    else $error("float from accumulator result wrong");
  a_exp_true_zero: assert property (
    (state == S_EXEC) && (op == OP_LOAD_EXPONENT) && (fd == 64'h0)
    |=> fpac[dst] == 64'h0)
    else $error("exponent load altered true zero");

endmodule // fdc_unit

/* inc/fdc_pkg.sv */
// Shared constants for the floating-point divide, convert and load unit.
package fdc_pkg;

  // Register byte offsets on the Wishbone slave.
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_FIXED = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_OPND_HI = 8'h0C;
  localparam logic [7:0] ADDR_OPND_LO = 8'h10;
  localparam logic [7:0] ADDR_FIX_RES = 8'h14;
  localparam logic [7:0] ADDR_FPAC_BASE = 8'h20;

  // Command register layout.
  localparam int CMD_W = 9;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DST_LSB = 5;
  localparam int CMD_SRC_LSB = 7;
  localparam int CMD_BUSY_BIT = 31;

  // Operation codes written to the command register.
  localparam logic [4:0] OP_COMPARE = 5'h00;
  localparam logic [4:0] OP_DIV_DOUBLE_REG = 5'h01;
  localparam logic [4:0] OP_DIV_DOUBLE_MEM = 5'h02;
  localparam logic [4:0] OP_DIV_SINGLE_MEM = 5'h03;
  localparam logic [4:0] OP_DIV_SINGLE_REG = 5'h04;
  localparam logic [4:0] OP_LOAD_EXPONENT = 5'h05;
  localparam logic [4:0] OP_FIX_TO_ACC = 5'h06;
  localparam logic [4:0] OP_FIX_TO_MEM = 5'h07;
  localparam logic [4:0] OP_HALVE = 5'h08;
  localparam logic [4:0] OP_INTEGERIZE = 5'h09;
  localparam logic [4:0] OP_FLOAT_FROM_ACC = 5'h0A;
  localparam logic [4:0] OP_LOAD_DOUBLE = 5'h0B;
  localparam logic [4:0] OP_LOAD_SINGLE = 5'h0C;
  localparam logic [4:0] OP_FLOAT_FROM_MEM = 5'h0D;
  localparam logic [4:0] OP_LOAD_STATUS = 5'h0E;

  // Float layout: sign, excess-64 hex exponent, 56-bit mantissa.
  localparam int F_SIGN = 63;
  localparam int F_EXP_LSB = 56;
  localparam int MANT_W = 56;
  localparam logic [7:0] EXP_BIAS = 8'h40;
  localparam logic [7:0] INT_DIGITS = 8'h10;
  localparam logic [7:0] KEEP_DIGITS = 8'h0E;
  localparam logic [6:0] EXP_FROM_ACC = 7'h44;
  localparam logic [6:0] EXP_FROM_MEM = 7'h48;
  localparam logic [9:0] EXP_MAX = 10'h07F;

  // Exponent field inside the fixed accumulator word.
  localparam int FX_EXP_MSB = 14;
  localparam int FX_EXP_LSB = 8;

  // Fix limits: magnitude of the most negative result.
  localparam logic [63:0] FIX_ACC_LIMIT = 64'h0000_0000_0000_8000;
  localparam logic [63:0] FIX_MEM_LIMIT = 64'h0000_0000_8000_0000;

  // Float status register bits.
  localparam int ST_ANY = 31;
  localparam int ST_OVF = 30;
  localparam int ST_UNDER = 29;
  localparam int ST_DVZ = 28;
  localparam int ST_MANT_OVF = 27;
  localparam int ST_Z = 25;
  localparam int ST_N = 24;
  localparam int ST_ID_LSB = 16;
  localparam int ST_ID_MSB = 19;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

  // Index of the last divider step; 64 quotient bits in all.
  localparam logic [6:0] DIV_LAST = 7'h3F;

  // Sequencer states.
  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_DIV, S_DIVEND} fdc_state_t;

endpackage

/* testbench/fdc_core_model.sv */
// Core-side bus master model that moves words to and from the unit.
`timescale 1ns/1ps
module fdc_core_model (
  // Clock.
  input wire logic clk,
  // Answer from the unit.
  input wire logic ack,
  input wire logic [31:0] rdat,
  // Request to the unit.
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] wdat
);
  // The bus is idle at time zero.
  initial begin
    {cyc, stb, we, adr, sel, wdat} = '0;
  end

  // One classic cycle, held until ack is sampled, then released.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // Released lines show the inverse so stale data is never trusted.
    wdat <= ~d;
    adr <= ~a;
    if (n >= 40) begin
      fdc_unit_tb.fails++;
      fdc_unit_tb.summarize();
    end
  endtask
endmodule // fdc_core_model

/* testbench/fdc_unit_tb.sv */
// Self-checking bench for the divide, convert and load unit.
`timescale 1ns/1ps
module fdc_unit_tb;
  import fdc_pkg::*;
  localparam logic [3:0] ID = 4'h9; // Arbitrary unit code.
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  int fails = 0;
  int comparisons = 0;
  localparam logic [63:0] ONE = 64'h4110_0000_0000_0000;
  localparam logic [63:0] TWO = 64'h4120_0000_0000_0000;
  localparam logic [63:0] HALF = 64'h4080_0000_0000_0000;
  // Three with junk in the low half, which single divides ignore.
  localparam logic [63:0] THREE_DIRTY = 64'h4130_0000_FFFF_FFFF;
  localparam logic [63:0] ONE_HALF = 64'h4118_0000_0000_0000;

  // Clock of 100 ns period.
  always #50 CLK = ~CLK;

  fdc_unit #(.ID_CODE(ID)) dut_u (.CLK(CLK), .RST_N(RST_N),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack));
  fdc_core_model m (.clk(CLK), .ack(ack), .rdat(rdat), .cyc(cyc),
    .stb(stb), .we(we), .adr(adr), .sel(sel), .wdat(wdat));

  // Counts a comparison and reports a mismatch.
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    m.xfer(1'b1, a, d, q);
  endtask
  // Reads a register and compares it.
  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    logic [31:0] q;
    m.xfer(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  // Issues a command and polls busy under a bound.
  task automatic run(input logic [4:0] op, input logic [1:0] d, s);
    logic [31:0] q;
    int n;
    wr(ADDR_CMD, {23'h0, s, d, op});
    n = 0;
    do begin
      m.xfer(1'b0, ADDR_CMD, 32'h0, q);
      n++;
    end while (q[31] !== 1'b0 && n < 100);
    if (n >= 100) begin
      fails++;
      summarize();
    end
  endtask
  // Loads an accumulator, high word first.
  task automatic ldd(input logic [1:0] i, input logic [63:0] v);
    wr(ADDR_OPND_HI, v[63:32]);
    wr(ADDR_OPND_LO, v[31:0]);
    run(OP_LOAD_DOUBLE, i, 2'h0);
  endtask
  task automatic fpc(input string nm, input logic [1:0] i,
                     input logic [63:0] e);
    rc(nm, ADDR_FPAC_BASE + {3'h0, i, 3'h0}, e[63:32]);
    rc(nm, ADDR_FPAC_BASE + {3'h0, i, 3'h4}, e[31:0]);
  endtask
  // Expected status word with the given flags.
  function automatic logic [31:0] st(input logic z, n);
    return {6'h0, z, n, 4'h0, ID, 16'h0};
  endfunction

  task automatic t_base();
    wr(8'h18, 32'hFFFF_FFFF);
    rc("unmapped", 8'h18, 32'h0);
    rc("status", ADDR_STATUS, st(1'b0, 1'b0));
    $display("base done");
  endtask
  task automatic t_load();
    ldd(2'h1, 64'h4110_0000_0000_0001);
    fpc("ld dbl", 2'h1, 64'h4110_0000_0000_0001);
    ldd(2'h2, 64'hC300_0000_0000_0000);
    fpc("ld zero", 2'h2, 64'h0);
    rc("ld flags", ADDR_STATUS, st(1'b1, 1'b0));
    wr(ADDR_OPND_HI, 32'hC110_0000);
    run(OP_LOAD_SINGLE, 2'h3, 2'h0);
    fpc("ld sgl", 2'h3, 64'hC110_0000_0000_0000);
    rc("sgl flags", ADDR_STATUS, st(1'b0, 1'b1));
    $display("load done");
  endtask
  task automatic t_cmp();
    logic [31:0] v [3] = '{32'h4120_0000, 32'h4110_0000, 32'h4080_0000};
    logic [1:0] e [3] = '{2'b01, 2'b10, 2'b00};
    ldd(2'h1, ONE);
    for (int k = 0; k < 3; k++) begin
      ldd(2'h0, {v[k], 32'h0});
      run(OP_COMPARE, 2'h1, 2'h0);
      rc("compare", ADDR_STATUS, st(e[k][1], e[k][0]));
    end
    $display("compare done");
  endtask
  // Divides accumulator one by two, held both in FPAC two and memory.
  task automatic dv(input logic [4:0] op, input logic [63:0] a, e);
    ldd(2'h1, a);
    ldd(2'h2, TWO);
    run(op, 2'h1, 2'h2);
    fpc("quotient", 2'h1, e);
    fpc("divisor", 2'h2, TWO);
  endtask
  task automatic t_div();
    dv(OP_DIV_DOUBLE_REG, ONE, HALF);
    dv(OP_DIV_DOUBLE_MEM, ONE, HALF);
    dv(OP_DIV_SINGLE_REG, THREE_DIRTY, ONE_HALF);
    dv(OP_DIV_SINGLE_MEM, THREE_DIRTY, ONE_HALF);
    rc("div flags", ADDR_STATUS, st(1'b0, 1'b0));
    $display("divide done");
  endtask
  task automatic t_conv();
    wr(ADDR_OPND_HI, 32'hFFFF_FFFF);
    run(OP_FLOAT_FROM_MEM, 2'h0, 2'h0);
    fpc("flt mem", 2'h0, 64'hC110_0000_0000_0000);
    run(OP_FIX_TO_ACC, 2'h0, 2'h0);
    rc("fix acc", ADDR_FIXED, 32'h0000_FFFF);
    rc("fix flags", ADDR_STATUS, st(1'b0, 1'b0));
    run(OP_FIX_TO_MEM, 2'h0, 2'h0);
    rc("fix mem", ADDR_FIX_RES, 32'hFFFF_FFFF);
    ldd(2'h0, 64'hC510_0000_0000_0000);
    run(OP_FIX_TO_ACC, 2'h0, 2'h0);
    rc("fix wrap", ADDR_FIXED, 32'h0);
    rc("overflow", ADDR_STATUS, 32'h8809_0000);
    wr(ADDR_FIXED, 32'h0000_0002);
    run(OP_FLOAT_FROM_ACC, 2'h3, 2'h0);
    fpc("flt acc", 2'h3, TWO);
    run(OP_HALVE, 2'h3, 2'h0);
    fpc("halve", 2'h3, ONE);
    wr(ADDR_FIXED, 32'h0000_4300);
    run(OP_LOAD_EXPONENT, 2'h3, 2'h0);
    fpc("exponent", 2'h3, 64'h4310_0000_0000_0000);
    ldd(2'h3, 64'h4080_0000_0000_0000);
    run(OP_INTEGERIZE, 2'h3, 2'h0);
    fpc("integerize", 2'h3, 64'h0);
    wr(ADDR_OPND_HI, 32'h020F_0000);
    run(OP_LOAD_STATUS, 2'h0, 2'h0);
    rc("ld status", ADDR_STATUS, st(1'b1, 1'b0));
    $display("convert done");
  endtask
  // Empty mantissa, true zero, most negative fix, halve underflow.
  task automatic t_corner();
    wr(ADDR_FPAC_BASE + 8'h18, 32'hC300_0000);
    run(OP_LOAD_EXPONENT, 2'h3, 2'h0);
    fpc("exp empty", 2'h3, 64'h0);
    run(OP_LOAD_EXPONENT, 2'h3, 2'h0);
    fpc("exp zero", 2'h3, 64'h0);
    ldd(2'h0, 64'hC480_0000_0000_0000);
    run(OP_FIX_TO_ACC, 2'h0, 2'h0);
    rc("fix min", ADDR_FIXED, 32'h0000_8000);
    rc("min flags", ADDR_STATUS, st(1'b0, 1'b0));
    ldd(2'h1, 64'h0010_0000_0000_0000);
    run(OP_HALVE, 2'h1, 2'h0);
    fpc("halve under", 2'h1, 64'h7F80_0000_0000_0000);
    rc("under flags", ADDR_STATUS,
       st(1'b0, 1'b0) | 32'hA000_0000);
    $display("corner done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Reset for five cycles, then the scenarios in turn.
  initial begin
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    t_base();
    t_load();
    t_cmp();
    t_div();
    t_conv();
    t_corner();
    summarize();
  end
endmodule // fdc_unit_tb
